// ### hw/ident_lock_ctl.v
// write-once selector lock and pending interface choice
`include "ident_regs.vh"

module ident_lock_ctl #(
  parameter [1:0] CHOICE_RESET = `CHOICE_BUFFER
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // init event and write strobe
  input  wire        init_evt_i,
  input  wire        wr_i,
  input  wire [31:0] wdata_i,
  // state
  output reg         lock_o,
  output reg  [1:0]  choice_o,
  output reg  [1:0]  active_o
);

  wire choice_ok = (wdata_i[`IFID_CHOICE_HI:`IFID_CHOICE_LO] == `CHOICE_STREAM) ||
                   (wdata_i[`IFID_CHOICE_HI:`IFID_CHOICE_LO] == `CHOICE_BUFFER);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_o   <= 1'b0;
      choice_o <= CHOICE_RESET;
      active_o <= CHOICE_RESET;
    end else if (init_evt_i) begin
      lock_o   <= 1'b0;                 // [R9]
      active_o <= choice_o;             // [R11]
    end else if (wr_i) begin
      // choice is judged against the lock held before this write, so one
      // write may set the choice and lock it together
      if (!lock_o && choice_ok) begin
        choice_o <= wdata_i[`IFID_CHOICE_HI:`IFID_CHOICE_LO]; // [R8] [R11]
      end
      if (wdata_i[`IFID_LOCK_BIT]) begin
        lock_o <= 1'b1;                 // [R8]
      end                               // a zero is ignored [R7]
    end
  end

endmodule

// ### hw/ident_regs.vh
// register offsets, field positions and codes of the interface identity registers
//
// Notes on behaviour
// R1: identity word bits 31:16 hold device code
// R2: bits 15:0 hold maker code, low byte low
// R3: revision register bits 7:0 report component revision
// R4: identifier register shared by every locality window
// R5: identity and revision at own addresses, separate
// R6: identifier shows supported, version and active kind
// R7: writing zero to lock bit 19 is ignored
// R8: writing one sets lock, freezes interface choice
// R9: module init event clears the lock
// R10: bits 31:20 read zero, writes ignored
// R11: bits 18:17 choose port kind, apply at init
// R12: bits 3:0 report active port kind
`ifndef IDENT_REGS_VH
`define IDENT_REGS_VH

// byte offsets inside one 4 KiB locality window
`define WIN_OFS_IFACE_ID    12'h030
`define WIN_OFS_DEV_VENDOR  12'hf00
`define WIN_OFS_REVISION    12'hf04
`define WIN_OFS_BITS        12
`define LOCALITY_COUNT      5

// interface identifier fields
`define IFID_LOCK_BIT       19
`define IFID_CHOICE_HI      18
`define IFID_CHOICE_LO      17
`define IFID_CAP_BUF_BIT    14
`define IFID_CAP_STRM_BIT   13
`define IFID_CAP_LOC_BIT    8
`define IFID_VER_HI         7
`define IFID_VER_LO         4
`define IFID_KIND_HI        3
`define IFID_KIND_LO        0

// selector and kind codes
`define CHOICE_STREAM       2'h0
`define CHOICE_BUFFER       2'h1
`define KIND_NEW_STREAM     4'h0
`define KIND_BUFFER         4'h1
`define KIND_LEGACY_STREAM  4'hf
`define VER_STREAM          4'h0
`define VER_BUFFER          4'h1

`endif

// ### hw/ident_regs_top.v
// apb slave holding identity, revision and interface identifier registers
`include "ident_regs.vh"

module ident_regs_top #(
  parameter [15:0] DEVICE_CODE   = 16'h0001, // arbitrary value
  parameter [15:0] MAKER_CODE    = 16'h00a5, // arbitrary value
  parameter [7:0]  REVISION_CODE = 8'h01,    // arbitrary value
  parameter        ADDR_W        = 15
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              sys_rst_i,
  // module initialisation event, one-cycle pulse
  input  wire              module_init_event_i,
  // apb slave
  input  wire              psel_i,
  input  wire              penable_i,
  input  wire              pwrite_i,
  input  wire [ADDR_W-1:0] paddr_i,
  input  wire [31:0]       pwdata_i,
  output reg  [31:0]       prdata_o,
  output reg               pready_o,
  output reg               pslverr_o,
  // state for the rest of the module
  output reg               selector_lock_o,
  output reg  [1:0]        interface_choice_o,
  output reg  [3:0]        active_port_kind_o
);

  // the answer is registered, so every transfer has one wait state: the
  // access edge launches pready and the next edge completes the transfer
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  // register selects inside one window, one-hot
  localparam integer     SEL_W    = 3;
  localparam [SEL_W-1:0] SEL_NONE = 3'b000;
  localparam [SEL_W-1:0] SEL_IFID = 3'b001;
  localparam [SEL_W-1:0] SEL_DV   = 3'b010;
  localparam [SEL_W-1:0] SEL_REV  = 3'b100;

  localparam integer IDX_W = ADDR_W - `WIN_OFS_BITS;

  // offset inside a window to register select
  function [SEL_W-1:0] reg_sel;
    input [`WIN_OFS_BITS-1:0] ofs;
    begin
      case (ofs)
        `WIN_OFS_IFACE_ID: begin
          reg_sel = SEL_IFID;                              // [R4]
        end
        `WIN_OFS_DEV_VENDOR: begin
          reg_sel = SEL_DV;                                // [R5]
        end
        `WIN_OFS_REVISION: begin
          reg_sel = SEL_REV;                               // [R5]
        end
        default: begin
          reg_sel = SEL_NONE;
        end
      endcase
    end
  endfunction

  // active kind code of a port choice; the legacy code is never reported
  // because this block always implements the newer register layout
  function [3:0] kind_of;
    input [1:0] c;
    begin
      kind_of = (c == `CHOICE_BUFFER) ? `KIND_BUFFER : `KIND_NEW_STREAM;
    end
  endfunction

  // interface version that goes with a port choice
  function [3:0] version_of;
    input [1:0] c;
    begin
      version_of = (c == `CHOICE_BUFFER) ? `VER_BUFFER : `VER_STREAM;
    end
  endfunction

  wire [`WIN_OFS_BITS-1:0]   win_ofs = paddr_i[`WIN_OFS_BITS-1:0];
  wire [IDX_W-1:0]           win_idx = paddr_i[ADDR_W-1:`WIN_OFS_BITS];
  wire [`LOCALITY_COUNT-1:0] win_match;
  wire                       in_window;
  wire [SEL_W-1:0]           sel;
  wire                       mapped;

  // one comparator per locality window; all windows alias one register set
  genvar gi;
  generate
    for (gi = 0; gi < `LOCALITY_COUNT; gi = gi + 1) begin : g_win
      localparam integer WIN_NUM = gi;
      assign win_match[gi] = ({{(32-IDX_W){1'b0}}, win_idx} == WIN_NUM); // [R4]
    end
  endgenerate

  assign in_window = |win_match;
  assign sel       = in_window ? reg_sel(win_ofs) : SEL_NONE;
  assign mapped    = (sel != SEL_NONE);

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  wire       bus_access;
  wire       take;
  wire       finish;
  wire       wr_ifid;

  assign bus_access = psel_i && penable_i;
  // take: first access edge, where the answer is launched
  assign take       = bus_access && (state_reg == ST_IDLE);
  // finish: edge at which the master sees pready; writes land only here
  assign finish     = bus_access && (state_reg == ST_ANSWER);
  assign wr_ifid    = finish && pwrite_i && (sel == SEL_IFID);  // [R4]

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bus_access) begin
          state_next = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        // back to idle even if the master stalls, so pready is one cycle
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  wire       lock;
  wire [1:0] choice;
  wire [1:0] active;

  ident_lock_ctl u_lock (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .init_evt_i (module_init_event_i),
    .wr_i       (wr_ifid),
    .wdata_i    (pwdata_i),
    .lock_o     (lock),
    .choice_o   (choice),
    .active_o   (active)
  );

  // interface identifier as read; unlisted bits stay zero
  reg [31:0] ifid_word;
  always @* begin
    ifid_word = 32'h0;                                             // [R10]
    ifid_word[`IFID_LOCK_BIT]                  = lock;             // [R8]
    ifid_word[`IFID_CHOICE_HI:`IFID_CHOICE_LO] = choice;           // [R11]
    ifid_word[`IFID_CAP_BUF_BIT]               = 1'b1;             // [R6]
    ifid_word[`IFID_CAP_STRM_BIT]              = 1'b1;             // [R6]
    ifid_word[`IFID_CAP_LOC_BIT]               = 1'b1;             // [R6]
    ifid_word[`IFID_VER_HI:`IFID_VER_LO]       = version_of(active); // [R6]
    ifid_word[`IFID_KIND_HI:`IFID_KIND_LO]     = kind_of(active);    // [R12]
  end

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0;
    case (sel)
      SEL_IFID: begin
        rd_next = ifid_word;                                       // [R6]
      end
      SEL_DV: begin
        // maker code keeps its low byte in the low byte lane
        rd_next = {DEVICE_CODE, MAKER_CODE[15:8], MAKER_CODE[7:0]}; // [R1] [R2]
      end
      SEL_REV: begin
        rd_next = {24'h0, REVISION_CODE};                          // [R3]
      end
      default: begin
        rd_next = 32'h0;
      end
    endcase
  end

  // unmapped offsets and windows above the last locality answer with an
  // error and have no effect
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= take;
      pslverr_o <= take && !mapped;
    end
  end

  // read data stands only in the answer cycle and is zero otherwise
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
    end else if (take && !pwrite_i) begin
      prdata_o <= rd_next;
    end else begin
      prdata_o <= 32'h0;
    end
  end

  // registered copies of the selector state for the rest of the module;
  // they trail the internal state by one cycle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      selector_lock_o    <= 1'b0;
      interface_choice_o <= 2'h0;
      active_port_kind_o <= 4'h0;
    end else begin
      selector_lock_o    <= lock;                   // [R8]
      interface_choice_o <= choice;                 // [R11]
      active_port_kind_o <= kind_of(active);        // [R12]
    end
  end

endmodule

// ### tb/ident_regs_monitor.sv
// assertion checker for the identity register block
module ident_regs_monitor (
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic        module_init_event_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [14:0] paddr_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        selector_lock_o,
  input logic [1:0]  interface_choice_o,
  input logic [3:0]  active_port_kind_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence rd_at(a);
    pready_o && !pwrite_i && paddr_i[14:12] < 3'h5 && paddr_i[11:0] == a;
  endsequence
  AST_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready");
  AST_IDENT: assert property (rd_at(12'hf00) |-> prdata_o == 32'h000100a5)
    else $error("bad identity");
  AST_REVISION: assert property (rd_at(12'hf04) |-> prdata_o == 32'h00000001)
    else $error("bad revision");
  AST_IFID: assert property (rd_at(12'h030) |-> prdata_o[31:20] == 12'h000
    && prdata_o[3:0] == active_port_kind_o) else $error("bad identifier");
  AST_LOCK_HOLD: assert property (selector_lock_o && !module_init_event_i
    && !$past(module_init_event_i) |=> selector_lock_o) else $error("lock lost");
  AST_LOCK_CLEAR: assert property (module_init_event_i |-> ##2 !selector_lock_o)
    else $error("lock kept");
  AST_CHOICE_FROZEN: assert property (selector_lock_o |=> $stable(interface_choice_o))
    else $error("choice moved");
  AST_KIND_CODE: assert property (active_port_kind_o inside {4'h0, 4'h1})
    else $error("bad kind");
endmodule

// ### tb/interface_identity_registers_test.sv
// self-checking bench for the identity register block
module interface_identity_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, sys_rst_i = 1, init_i = 0;
  logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [14:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic        pready_o, pslverr_o, lock_o, err;
  logic [1:0]  choice_o;
  logic [3:0]  kind_o;
  int          fail_count = 0, tests_run = 0;
  int          k;
  logic [14:0] a;
  always #25 clk_i = ~clk_i;
  ident_regs_top dut (.clk_i, .sys_rst_i, .module_init_event_i(init_i), .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .selector_lock_o(lock_o), .interface_choice_o(choice_o), .active_port_kind_o(kind_o));
  task automatic close_out();
    $display("errors %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle edge first, so psel never drops and rises in one step
  task automatic xfer(logic w, logic [14:0] a, logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic pulse_init();
    @(posedge clk_i) init_i <= 1;
    @(posedge clk_i) init_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  // version field follows the kind for both supported kinds
  function automatic logic [31:0] exp_id(logic l, logic [1:0] c, logic [3:0] k);
    return {12'h000, l, c, 4'h3, 4'h0, 1'b1, k, k};
  endfunction
  function automatic logic [31:0] exp_at(logic [11:0] o, logic [31:0] id);
    return (o == 12'hf00) ? 32'h000100a5 : (o == 12'hf04) ? 32'h00000001 : id;
  endfunction
  initial begin
    void'($urandom(32'hd22e701d));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 0;
    for (int l = 0; l < 5; l++) begin
      xfer(0, {l[2:0], 12'hf00}, 0);
      chk(rd, 32'h000100a5);
      xfer(0, {l[2:0], 12'hf04}, 0);
      chk(rd, 32'h00000001);
      xfer(0, {l[2:0], 12'h030}, 0);
      chk(rd, exp_id(0, 1, 1));
    end
    // random windows and registers read back the reset state
    for (int n = 0; n < 24; n++) begin
      k = $urandom_range(2);
      a = {3'($urandom_range(4)), (k == 0) ? 12'h030 : (k == 1) ? 12'hf00 : 12'hf04};
      xfer(0, a, 0);
      chk(rd, exp_at(a[11:0], exp_id(0, 1, 1)));
      chk({31'h0, err}, 0);
    end
    xfer(1, 15'h3030, $urandom & 32'hfff00000);
    xfer(0, 15'h1030, 0);
    chk(rd, exp_id(0, 0, 1));
    chk({30'h0, choice_o}, 0);
    pulse_init();
    xfer(0, 15'h0030, 0);
    chk(rd, exp_id(0, 0, 0));
    chk({28'h0, kind_o}, 0);
    xfer(1, 15'h2030, 32'h000a0000 | ($urandom & 32'hfff00000));
    xfer(1, 15'h4030, 0);
    xfer(0, 15'h0030, 0);
    chk(rd, exp_id(1, 1, 0));
    chk({31'h0, lock_o}, 1);
    chk({30'h0, choice_o}, 1);
    pulse_init();
    xfer(0, 15'h0030, 0);
    chk(rd, exp_id(0, 1, 1));
    chk({28'h0, kind_o}, 1);
    xfer(0, 15'h0004, 0);
    chk({31'h0, err}, 1);
    close_out();
  end
  initial begin
    #200us;
    fail_count++;
    close_out();
  end
endmodule
bind ident_regs_top ident_regs_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .module_init_event_i(module_init_event_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .selector_lock_o(selector_lock_o), .interface_choice_o(interface_choice_o),
  .active_port_kind_o(active_port_kind_o));
